/* File: design/spp_pkg.sv */
// constants, register map and state encoding for the serial peripheral port
package spp_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] SPP_CTRL_OFS = 8'h0d;
    localparam logic [7:0] SPP_STATUS_OFS = 8'h0e;
    localparam logic [7:0] SPP_DATA_OFS = 8'h0f;

    // serial_control_reg field positions
    localparam int SPP_CTRL_IRQ_EN_BIT = 7;
    localparam int SPP_CTRL_ENABLE_BIT = 6;
    localparam int SPP_CTRL_LSB_FIRST_BIT = 5;
    localparam int SPP_CTRL_MASTER_BIT = 4;
    localparam int SPP_CTRL_IDLE_LVL_BIT = 3;
    localparam int SPP_CTRL_PHASE_BIT = 2;
    localparam int SPP_CTRL_RATE_HI_BIT = 1;
    localparam int SPP_CTRL_RATE_LO_BIT = 0;

    // serial_status_reg field positions
    localparam int SPP_STAT_DONE_BIT = 7;
    localparam int SPP_STAT_WRITE_COLLISION_FLAG_BIT = 6;

    // reset values
    localparam logic [7:0] SPP_CTRL_RESET = 8'h00;
    localparam logic [7:0] SPP_DATA_RESET = 8'h00;
    localparam logic [5:0] SPP_STAT_RESERVED = 6'h00;

    // sck half periods in oscillator cycles for divisors 4, 16, 64, 128
    localparam logic [6:0] SPP_HALF_DIV4 = 7'h02;
    localparam logic [6:0] SPP_HALF_DIV16 = 7'h08;
    localparam logic [6:0] SPP_HALF_DIV64 = 7'h20;
    localparam logic [6:0] SPP_HALF_DIV128 = 7'h40;

    // last bit index of a byte and last sck edge index of a master byte
    localparam logic [2:0] SPP_LAST_BIT = 3'h7;
    localparam logic [3:0] SPP_LAST_EDGE = 4'hf;

    typedef enum logic [1:0] {
        SPP_IDLE = 2'b00,
        SPP_MASTER_RUN = 2'b01,
        SPP_SLAVE_SEL = 2'b10
    } spp_state_t;

endpackage : spp_pkg

/* File: design/spp_rate_div.sv */
// master sck half-period tick generator
`timescale 1ns/1ps
module spp_rate_div
    import spp_pkg::*;
#(
    parameter int CNT_W = 7
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    // control
    input wire logic run,
    input wire logic [1:0] rate_sel,
    // one-cycle tick per sck half period
    output logic tick
);

    if (CNT_W < 7) begin : g_width_check
        $error("spp_rate_div: CNT_W too small for divisor 128");
    end

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] half;

    always_comb begin
        case (rate_sel)
            2'b00: half = CNT_W'(SPP_HALF_DIV4);
            2'b01: half = CNT_W'(SPP_HALF_DIV16);
            2'b10: half = CNT_W'(SPP_HALF_DIV64);
            default: half = CNT_W'(SPP_HALF_DIV128);
        endcase
    end

    // counter restarts from zero each time the generator is started
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (clk_en) begin
            if (!run) begin
                cnt <= '0;
                tick <= 1'b0;
            end else if (cnt == half - CNT_W'(1)) begin
                cnt <= '0;
                tick <= 1'b1;
            end else begin
                cnt <= cnt + CNT_W'(1);
                tick <= 1'b0;
            end
        end
    end

endmodule : spp_rate_div

/* File: design/spp_core.sv */
// serial peripheral port: registers, master/slave shift engine, pin control
//
// How it works
// RQ1: master with select pin as output: that pin is ignored by the port.
// RQ2: master with select pin as input: outside logic keeps it high.
// RQ3: select input low while master: clear master_select, become slave, release pins.
// RQ4: that forced drop sets transfer_done_flag and may request an interrupt.
// RQ5: after the drop, stay slave until software sets master_select again.
// RQ6: selected slave: miso driven only if user direction says output.
// RQ7: deselected slave: all pins inputs, data ignored, shift logic reset.
// RQ8: select rising mid-byte stops shifting at once; both bytes are lost.
// RQ9: clock_idle_level gives the idle level of sck.
// RQ10: phase zero samples on leading edge; phase one samples on trailing.
// RQ11: interrupt requested when enable, done flag and global enable are set.
// RQ12: nothing happens unless serial_port_enable is one.
// RQ13: bit_order_lsb_first picks lsb-first, else msb-first shifting.
// RQ14: master_select one means master, zero means slave.
// RQ15: master sck is clock divided by 4, 16, 64 or 128.
// RQ16: rate select ignored in slave mode; sck comes from outside.
// RQ17: transfer_done_flag set when a byte transfer completes.
// RQ18: transfer_done_flag cleared when the interrupt vector executes.
// RQ19: status read with flag set, then data access, clears the flag.
// RQ20: data write during a transfer sets write_collision_flag.
// RQ21: status read with collision set, then data access, clears both flags.
// RQ22: low six status bits read zero.
// RQ23: data write starts transmission; data read returns receive buffer.
// RQ24: master runs sck for one byte, then stops and sets done flag.
// RQ25: transmit single buffered, receive double buffered; unread byte overwritten.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module spp_core
    import spp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock, reset, freeze
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    // interrupt handshake with the core
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    output logic irq_req,
    // user pin directions, one means output
    input wire logic mosi_dir_out,
    input wire logic miso_dir_out,
    input wire logic sck_dir_out,
    input wire logic ss_dir_out,
    // serial clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    // master-out pin
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    // master-in pin
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    // slave select, active low
    input wire logic ss_n_in
);

    if (ADDR_W < 4) begin : g_addr_check
        $error("spp_core: ADDR_W too small for register map");
    end

    spp_state_t state;
    spp_state_t next_state;

    logic [7:0] serial_control_reg;
    logic [7:0] shifter;
    logic [7:0] next_shifter;
    logic [7:0] rx_buf;
    logic [2:0] bit_cnt;
    logic [3:0] edge_cnt;
    logic out_bit;
    logic sck_prev;
    logic transfer_done_flag;
    logic write_collision_flag;
    logic armed_done;
    logic armed_write_collision_flag;
    logic tick;

    // control fields
    logic irq_en;
    logic port_en;
    logic lsb_first;
    logic master_select;
    logic idle_lvl;
    logic phase;

    assign irq_en = serial_control_reg[SPP_CTRL_IRQ_EN_BIT];
    assign port_en = serial_control_reg[SPP_CTRL_ENABLE_BIT];
    assign lsb_first = serial_control_reg[SPP_CTRL_LSB_FIRST_BIT];
    assign master_select = serial_control_reg[SPP_CTRL_MASTER_BIT];
    assign idle_lvl = serial_control_reg[SPP_CTRL_IDLE_LVL_BIT];
    assign phase = serial_control_reg[SPP_CTRL_PHASE_BIT];

    // register access decode
    logic wr_ctrl;
    logic wr_data;
    logic rd_status;
    logic rd_data;
    logic data_access;

    assign wr_ctrl = wr_stb && (addr == ADDR_W'(SPP_CTRL_OFS));
    assign wr_data = wr_stb && (addr == ADDR_W'(SPP_DATA_OFS));
    assign rd_status = rd_stb && (addr == ADDR_W'(SPP_STATUS_OFS));
    assign rd_data = rd_stb && (addr == ADDR_W'(SPP_DATA_OFS));
    assign data_access = wr_data || rd_data;

    // another master pulling select low; only counts when select is an input
    logic force_drop;
    assign force_drop = port_en && master_select && !ss_dir_out && !ss_n_in; // [RQ3] [RQ1]

    // edge events from the master generator or the external clock
    logic m_run;
    logic s_sel;
    logic m_lead;
    logic m_trail;
    logic s_edge;
    logic s_lead;
    logic lead_ev;
    logic trail_ev;
    logic sample_ev;
    logic change_ev;
    logic m_last;
    logic xfer_done;
    logic busy;
    logic write_ok;
    logic in_bit;

    assign m_run = (state == SPP_MASTER_RUN);
    assign s_sel = (state == SPP_SLAVE_SEL);
    assign m_lead = m_run && tick && !edge_cnt[0];
    assign m_trail = m_run && tick && edge_cnt[0];
    assign s_edge = s_sel && (sck_in != sck_prev);
    assign s_lead = s_edge && (sck_prev == idle_lvl);
    assign lead_ev = m_lead || s_lead;
    assign trail_ev = m_trail || (s_edge && !s_lead);
    assign sample_ev = phase ? trail_ev : lead_ev; // [RQ10]
    assign change_ev = phase ? lead_ev : trail_ev; // [RQ10]
    assign m_last = m_trail && (edge_cnt == SPP_LAST_EDGE);
    assign xfer_done = m_run ? m_last : (s_sel && sample_ev && bit_cnt == SPP_LAST_BIT);
    assign busy = m_run || (s_sel && bit_cnt != 3'h0);
    assign write_ok = wr_data && !busy; // [RQ25]
    assign in_bit = m_run ? miso_in : mosi_in;
    assign next_shifter = lsb_first ? {in_bit, shifter[7:1]} : {shifter[6:0], in_bit}; // [RQ13]

    spp_rate_div #(
        .CNT_W(7)
    ) u_rate_div (
        .clock(clock),
        .nrst(nrst),
        .clk_en(clk_en),
        .run(m_run), // [RQ16]
        .rate_sel(serial_control_reg[SPP_CTRL_RATE_HI_BIT:SPP_CTRL_RATE_LO_BIT]), // [RQ15]
        .tick(tick)
    );

    // mode sequencing
    always_comb begin
        next_state = state;
        case (state)
            SPP_IDLE: begin
                if (port_en && master_select && !force_drop && wr_data) begin
                    next_state = SPP_MASTER_RUN; // [RQ23] [RQ14] [RQ12]
                end else if (port_en && !master_select && !ss_n_in) begin
                    next_state = SPP_SLAVE_SEL; // [RQ6]
                end
            end
            SPP_MASTER_RUN: begin
                if (!port_en || !master_select || force_drop || m_last) begin
                    next_state = SPP_IDLE; // [RQ24]
                end
            end
            SPP_SLAVE_SEL: begin
                if (!port_en || master_select || ss_n_in) begin
                    next_state = SPP_IDLE; // [RQ7] [RQ8]
                end
            end
            default: next_state = SPP_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= SPP_IDLE;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // control register; hardware drop beats a same-cycle software write
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            serial_control_reg <= SPP_CTRL_RESET;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                serial_control_reg <= wdata; // [RQ5]
            end
            if (force_drop) begin
                serial_control_reg[SPP_CTRL_MASTER_BIT] <= 1'b0; // [RQ3]
            end
        end
    end

    // shift register and bit counter
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            shifter <= SPP_DATA_RESET;
            bit_cnt <= 3'h0;
        end else if (clk_en) begin
            if (sample_ev && (next_state != SPP_IDLE || m_last)) begin
                shifter <= next_shifter;
                bit_cnt <= bit_cnt + 3'h1;
            end else if (write_ok) begin
                shifter <= wdata; // [RQ23]
            end
            if (next_state != state || xfer_done) begin
                bit_cnt <= 3'h0; // [RQ7] [RQ8]
            end
        end
    end

    // master edge counter, 16 edges per byte
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            edge_cnt <= 4'h0;
        end else if (clk_en) begin
            if (!m_run) begin
                edge_cnt <= 4'h0;
            end else if (tick) begin
                edge_cnt <= edge_cnt + 4'h1;
            end
        end
    end

    // receive buffer; an unread byte is simply overwritten
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_buf <= SPP_DATA_RESET;
        end else if (clk_en) begin
            if (xfer_done) begin
                rx_buf <= sample_ev ? next_shifter : shifter; // [RQ25] [RQ24]
            end
        end
    end

    // serial output bit, shared by both data pins
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_bit <= 1'b0;
        end else if (clk_en) begin
            if (write_ok) begin
                out_bit <= lsb_first ? wdata[0] : wdata[7]; // [RQ13]
            end else if (change_ev) begin
                out_bit <= lsb_first ? shifter[0] : shifter[7]; // [RQ10]
            end else if (state == SPP_IDLE && next_state == SPP_SLAVE_SEL) begin
                out_bit <= lsb_first ? shifter[0] : shifter[7];
            end
        end
    end

    // external clock history; inputs are already synchronous
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sck_prev <= 1'b0;
        end else if (clk_en) begin
            sck_prev <= s_sel ? sck_in : idle_lvl;
        end
    end

    // completion flag: set wins over any clear in the same cycle
    logic done_set;
    logic done_clr;
    assign done_set = xfer_done || force_drop; // [RQ17] [RQ4]
    assign done_clr = irq_vector_ack || ((armed_done || armed_write_collision_flag) && data_access);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            transfer_done_flag <= 1'b0;
        end else if (clk_en) begin
            if (done_set) begin
                transfer_done_flag <= 1'b1;
            end else if (done_clr) begin
                transfer_done_flag <= 1'b0; // [RQ18] [RQ19] [RQ21]
            end
        end
    end

    // collision flag; the rejected byte is dropped, not queued
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            write_collision_flag <= 1'b0;
        end else if (clk_en) begin
            if (wr_data && busy) begin
                write_collision_flag <= 1'b1; // [RQ20]
            end else if (armed_write_collision_flag && data_access) begin
                write_collision_flag <= 1'b0; // [RQ21]
            end
        end
    end

    // status read arms the clear; the next data access fires it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            armed_done <= 1'b0;
            armed_write_collision_flag <= 1'b0;
        end else if (clk_en) begin
            if (rd_status) begin
                armed_done <= transfer_done_flag; // [RQ19]
                armed_write_collision_flag <= write_collision_flag; // [RQ21]
            end else if (data_access) begin
                armed_done <= 1'b0;
                armed_write_collision_flag <= 1'b0;
            end
        end
    end

    // read data stand for one cycle only
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (clk_en) begin
            rdata <= 8'h00;
            if (rd_stb) begin
                if (addr == ADDR_W'(SPP_CTRL_OFS)) begin
                    rdata <= serial_control_reg;
                end else if (addr == ADDR_W'(SPP_STATUS_OFS)) begin
                    rdata <= {transfer_done_flag, write_collision_flag, SPP_STAT_RESERVED}; // [RQ22]
                end else if (addr == ADDR_W'(SPP_DATA_OFS)) begin
                    rdata <= rx_buf; // [RQ23]
                end
            end
        end
    end

    // interrupt request toward the core
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_req <= 1'b0;
        end else if (clk_en) begin
            irq_req <= irq_en && transfer_done_flag && global_irq_enable; // [RQ11] [RQ4]
        end
    end

    // master sck level: toggles per tick, rests at the idle level
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sck_out <= 1'b0;
        end else if (clk_en) begin
            if (m_run && next_state == SPP_MASTER_RUN && tick) begin
                sck_out <= ~sck_out;
            end else if (!m_run || next_state != SPP_MASTER_RUN) begin
                sck_out <= idle_lvl; // [RQ9]
            end
        end
    end

    // pin direction overrides, registered so outputs come from flops
    logic master_now;
    logic slave_active;
    assign master_now = port_en && master_select && !force_drop;
    assign slave_active = port_en && !master_select && !ss_n_in;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sck_oe <= 1'b0;
            mosi_oe <= 1'b0;
            miso_oe <= 1'b0;
        end else if (clk_en) begin
            sck_oe <= master_now && sck_dir_out; // [RQ3] [RQ12]
            mosi_oe <= master_now && mosi_dir_out; // [RQ3]
            miso_oe <= slave_active && miso_dir_out; // [RQ6] [RQ7]
        end
    end

    // one flop drives both data pins; only one of them is ever enabled
    assign mosi_out = out_bit;
    assign miso_out = out_bit;

endmodule : spp_core

/* File: verification/spp_core_checker.sv */
// assertion checker bound to the serial peripheral port core
`timescale 1ns/1ps
module spp_core_checker
    import spp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    // interrupt
    input wire logic global_irq_enable,
    input wire logic irq_vector_ack,
    input wire logic irq_req,
    // pins
    input wire logic sck_dir_out,
    input wire logic ss_dir_out,
    input wire logic ss_n_in,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    logic en_shadow;
    logic sck_q;
    logic [4:0] edge_cnt;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            en_shadow <= 1'b0;
        end else if (clk_en && wr_stb && addr == ADDR_W'(SPP_CTRL_OFS)) begin
            en_shadow <= wdata[SPP_CTRL_ENABLE_BIT];
        end
    end
    // any write restarts the count, so a collision write can only shorten it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sck_q <= 1'b0;
            edge_cnt <= 5'h00;
        end else begin
            sck_q <= sck_out;
            if (clk_en && wr_stb) begin
                edge_cnt <= 5'h00;
            end else if (sck_out != sck_q && edge_cnt != 5'h1f) begin
                edge_cnt <= edge_cnt + 5'h01;
            end
        end
    end
    a_reserved_zero: assert property (
        rd_stb && clk_en && addr == ADDR_W'(SPP_STATUS_OFS) |=> rdata[5:0] == SPP_STAT_RESERVED)
        else $error("status low bits not zero");
    a_irq_cause: assert property (
        $rose(irq_req) |-> $past(global_irq_enable))
        else $error("irq raised without global enable");
    a_irq_ack: assert property (
        irq_vector_ack && clk_en |-> ##2 !irq_req)
        else $error("irq still pending after vector ack");
    a_forced_drop: assert property (
        sck_oe && !ss_dir_out && !ss_n_in |-> ##[1:6] !sck_oe && !mosi_oe)
        else $error("master kept driving after select low");
    a_deselect_idle: assert property (
        ss_n_in [*5] |-> !miso_oe)
        else $error("miso driven while deselected");
    a_one_driver: assert property (
        !(sck_oe && miso_oe))
        else $error("master and slave drives at once");
    a_sck_dir: assert property (
        !sck_dir_out |=> !sck_oe)
        else $error("sck driven against user direction");
    a_disabled_quiet: assert property (
        !en_shadow && !$past(en_shadow) |-> !sck_oe && !mosi_oe && !miso_oe)
        else $error("pins driven while port disabled");
    a_byte_edges: assert property (
        edge_cnt <= 5'h10)
        else $error("more than sixteen sck edges for one byte");
    a_rate_min: assert property (
        sck_oe && $changed(sck_out) |=> $stable(sck_out))
        else $error("sck half period shorter than two cycles");
endmodule : spp_core_checker

bind spp_core spp_core_checker #(.ADDR_W(ADDR_W)) u_checker (.*);

/* File: verification/spp_far_slave.sv */
// behavioural far-side slave device used while the core is master
`timescale 1ns/1ps
module spp_far_slave (
    // link
    input wire logic sel_n,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // mode and data
    input wire logic clock_idle_level,
    input wire logic clock_sample_phase,
    input wire logic lsb_first,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    int cnt = 0;
    function automatic logic pick(input int i);
        return lsb_first ? tx_byte[i] : tx_byte[7 - i];
    endfunction : pick
    initial miso = 1'b0;
    always @(negedge sel_n) begin
        cnt = 0;
        if (!clock_sample_phase) miso = pick(0);
    end
    // released line shows the inverse so a stale bit never matches
    always @(posedge sel_n) miso = ~miso;
    always @(sck) begin
        if (!sel_n && cnt < 8) begin
            if ((sck !== clock_idle_level) ^ clock_sample_phase) begin
                rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
                cnt = cnt + 1;
            end else begin
                miso = pick(cnt);
            end
        end
    end
endmodule : spp_far_slave

/* File: verification/tb_top.sv */
// self-checking testbench for the serial peripheral port core
`timescale 1ns/1ps
module tb_top
    import spp_pkg::*;
;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic gie = 1'b0;
    logic ack = 1'b0;
    logic miso_dir = 1'b0;
    logic ss_dir = 1'b1;
    logic out_dir = 1'b1;
    logic ss_n = 1'b1;
    logic p_sel_n = 1'b1;
    logic m_sck = 1'b0;
    logic m_mosi = 1'b0;
    logic p_clock_idle_level = 1'b0;
    logic p_clock_sample_phase = 1'b0;
    logic p_lsb = 1'b0;
    logic [7:0] p_tx = 8'h00;
    logic [7:0] p_rx, rdata, got, tx, c;
    logic irq_req, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, p_miso;
    wire logic sck_w = sck_oe ? sck_out : m_sck;
    wire logic mosi_w = mosi_oe ? mosi_out : m_mosi;
    wire logic miso_w = miso_oe ? miso_out : p_miso;
    int bad_count = 0;
    int n_tests = 0;
    int divs[4] = '{4, 16, 64, 128};
    always #12.5 clock = ~clock;
    spp_core uut (.clock(clock), .nrst(nrst), .clk_en(1'b1), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .global_irq_enable(gie),
        .irq_vector_ack(ack), .irq_req(irq_req), .mosi_dir_out(out_dir),
        .miso_dir_out(miso_dir), .sck_dir_out(out_dir), .ss_dir_out(ss_dir), .sck_in(sck_w),
        .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
        .ss_n_in(ss_n));
    spp_far_slave far (.sel_n(p_sel_n), .sck(sck_w), .mosi(mosi_w), .miso(p_miso),
        .clock_idle_level(p_clock_idle_level), .clock_sample_phase(p_clock_sample_phase), .lsb_first(p_lsb), .tx_byte(p_tx), .rx_byte(p_rx));
    task automatic close_out;
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // every wait ends just after the edge so later reads see settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        tick(1);
        wr_stb <= 1'b0;
        tick(1);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        rd_stb <= 1'b1;
        tick(1);
        rd_stb <= 1'b0;
        chk(rdata, e);
        tick(1);
    endtask : rdchk
    task automatic mrun(input int h, input logic idle);
        int tog = 0;
        int first = 0;
        int gap = 0;
        logic prev;
        prev = sck_out;
        for (int i = 0; i < 3000 && tog < 16; i++) begin
            tick(1);
            if (sck_out !== prev) begin
                tog++;
                if (tog == 1) first = i;
                if (tog == 2) gap = i - first;
                prev = sck_out;
            end
        end
        if (tog != 16) begin
            bad_count++;
            close_out();
        end
        chk(8'(gap), 8'(h));
        chk(8'(sck_out), 8'(idle));
        tick(2);
    endtask : mrun
    task automatic sbyte(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            m_mosi <= d[7 - i];
            tick(4);
            got = {got[6:0], miso_w};
            m_sck <= 1'b1;
            tick(4);
            m_sck <= 1'b0;
        end
        tick(4);
    endtask : sbyte
    initial begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        tick(2);
        rdchk(SPP_CTRL_OFS, SPP_CTRL_RESET);
        rdchk(SPP_STATUS_OFS, 8'h00);
        rdchk(8'h40, 8'h00);
        for (int m = 0; m < 8; m++) begin
            c = {2'b01, m[2], 1'b1, m[0], m[1], m[1:0] ^ {m[2], 1'b0}};
            p_clock_idle_level <= m[0];
            p_clock_sample_phase <= m[1];
            p_lsb <= m[2];
            tx = 8'h5a ^ 8'(m * 37);
            p_tx <= ~tx;
            wr(SPP_CTRL_OFS, c);
            p_sel_n <= 1'b0;
            ss_n <= 1'b0;
            tick(1);
            wr(SPP_DATA_OFS, tx);
            mrun(divs[c[1:0]] / 2, m[0]);
            p_sel_n <= 1'b1;
            ss_n <= 1'b1;
            rdchk(SPP_CTRL_OFS, c);
            rdchk(SPP_STATUS_OFS, 8'h80);
            rdchk(SPP_DATA_OFS, ~tx);
            chk(p_rx, tx);
            rdchk(SPP_STATUS_OFS, 8'h00);
        end
        // collision while the last mode stays set, interrupt enabled
        wr(SPP_CTRL_OFS, 8'hfd);
        gie <= 1'b1;
        p_sel_n <= 1'b0;
        tick(1);
        wr(SPP_DATA_OFS, 8'h3c);
        wr(SPP_DATA_OFS, 8'hff);
        mrun(8, 1'b1);
        chk(8'(irq_req), 8'h01);
        chk(p_rx, 8'h3c);
        rdchk(SPP_STATUS_OFS, 8'hc0);
        rdchk(SPP_DATA_OFS, p_tx);
        rdchk(SPP_STATUS_OFS, 8'h00);
        p_sel_n <= 1'b1;
        tick(1);
        p_sel_n <= 1'b0;
        wr(SPP_DATA_OFS, 8'h11);
        mrun(8, 1'b1);
        gie <= 1'b0;
        tick(2);
        chk(8'(irq_req), 8'h00);
        gie <= 1'b1;
        tick(2);
        chk(8'(irq_req), 8'h01);
        ack <= 1'b1;
        tick(1);
        ack <= 1'b0;
        tick(2);
        chk(8'(irq_req), 8'h00);
        rdchk(SPP_STATUS_OFS, 8'h00);
        p_sel_n <= 1'b1;
        wr(SPP_CTRL_OFS, 8'h10);
        wr(SPP_DATA_OFS, 8'h77);
        tick(40);
        chk(8'({sck_oe, mosi_oe}), 8'h00);
        rdchk(SPP_STATUS_OFS, 8'h00);
        // select as input: held high keeps master, pulled low forces slave
        wr(SPP_CTRL_OFS, 8'hd0);
        ss_dir <= 1'b0;
        tick(4);
        chk(8'(sck_oe), 8'h01);
        out_dir <= 1'b0;
        tick(2);
        chk(8'({sck_oe, mosi_oe}), 8'h00);
        out_dir <= 1'b1;
        tick(2);
        ss_n <= 1'b0;
        tick(6);
        rdchk(SPP_CTRL_OFS, 8'hc0);
        chk(8'({sck_oe, mosi_oe}), 8'h00);
        chk(8'(irq_req), 8'h01);
        rdchk(SPP_STATUS_OFS, 8'h80);
        ss_n <= 1'b1;
        tick(4);
        rdchk(SPP_CTRL_OFS, 8'hc0);
        wr(SPP_CTRL_OFS, 8'h43);
        miso_dir <= 1'b1;
        wr(SPP_DATA_OFS, 8'hc3);
        chk(8'(miso_oe), 8'h00);
        ss_n <= 1'b0;
        tick(4);
        chk(8'({miso_oe, sck_oe, mosi_oe}), 8'h04);
        for (int i = 0; i < 3; i++) begin
            m_mosi <= i[0];
            tick(4);
            m_sck <= 1'b1;
            tick(4);
            m_sck <= 1'b0;
        end
        ss_n <= 1'b1;
        tick(4);
        rdchk(SPP_STATUS_OFS, 8'h00);
        wr(SPP_DATA_OFS, 8'hc3);
        ss_n <= 1'b0;
        tick(4);
        sbyte(8'ha5);
        chk(got, 8'hc3);
        rdchk(SPP_DATA_OFS, 8'ha5);
        sbyte(8'h3c);
        sbyte(8'h69);
        rdchk(SPP_STATUS_OFS, 8'h80);
        rdchk(SPP_DATA_OFS, 8'h69);
        close_out();
    end
endmodule : tb_top
